// ==== src/pcie_ext_cap_pkg.sv ====
package pcie_ext_cap_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] OFS_ERROR_CONTROL   = 12'h118;
  localparam logic [11:0] OFS_HEADER_LOG_1    = 12'h11C;
  localparam logic [11:0] OFS_HEADER_LOG_2    = 12'h120;
  localparam logic [11:0] OFS_HEADER_LOG_3    = 12'h124;
  localparam logic [11:0] OFS_HEADER_LOG_4    = 12'h128;
  localparam logic [11:0] OFS_SERIAL_CAP_HDR  = 12'h180;
  localparam logic [11:0] OFS_SERIAL_LOW      = 12'h184;
  localparam logic [11:0] OFS_SERIAL_HIGH     = 12'h188;
  localparam logic [11:0] OFS_VC_CAP_HDR      = 12'h200;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FLD_FIRST_ERROR_LSB   = 0;
  localparam int FLD_FIRST_ERROR_W     = 5;
  localparam int FLD_CRC_GEN_CAPABLE   = 5;
  localparam int FLD_CRC_GEN_ENABLE    = 6;
  localparam int FLD_CRC_CHECK_CAPABLE = 7;
  localparam int FLD_CRC_CHECK_ENABLE  = 8;
  localparam int FLD_CAP_ID_LSB        = 0;
  localparam int FLD_CAP_ID_W          = 16;
  localparam int FLD_CAP_VER_LSB       = 16;
  localparam int FLD_CAP_VER_W         = 4;
  localparam int FLD_NEXT_CAP_LSB      = 20;
  localparam int FLD_NEXT_CAP_W        = 12;
  localparam int HEADER_LOG_WORDS      = 4;

  // ****************************************************************
  // Reset and constant values
  // ****************************************************************
  localparam logic [4:0]  RST_FIRST_ERROR     = 5'h0;
  localparam logic        RST_CRC_GEN_CAPABLE = 1'h1;
  localparam logic        RST_CRC_GEN_ENABLE  = 1'h0;
  localparam logic        RST_CRC_CHK_CAPABLE = 1'h1;
  localparam logic        RST_CRC_CHK_ENABLE  = 1'h0;
  localparam logic [31:0] RST_HEADER_LOG      = 32'h0000_0000;
  localparam logic [15:0] SERIAL_CAP_ID       = 16'h0003;
  localparam logic [3:0]  SERIAL_CAP_VER      = 4'h1;
  localparam logic [15:0] VC_CAP_ID           = 16'h0002;
  localparam logic [3:0]  VC_CAP_VER          = 4'h1;
  localparam logic [11:0] RST_NEXT_CAP        = 12'h000;
  localparam logic [31:0] RST_SERIAL_LOW      = 32'h0000_0000;
  localparam logic [31:0] RST_SERIAL_HIGH     = 32'h0000_0000;
  localparam logic [31:0] READ_UNMAPPED       = 32'h0000_0000;

endpackage : pcie_ext_cap_pkg

// ==== src/error_header_log.sv ====
`timescale 1ns/100ps

module error_header_log (
  // Clock and power-on reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Error event
  input  wire logic        errReport,
  input  wire logic [4:0]  errIndex,
  input  wire logic [31:0] errHeader [pcie_ext_cap_pkg::HEADER_LOG_WORDS],
  input  wire logic        errLogRearm,
  // Captured state
  output logic             logLocked,
  output logic [4:0]       firstErrorIndex,
  output logic [31:0]      headerLogWord [pcie_ext_cap_pkg::HEADER_LOG_WORDS]
);

  logic captureNow;

  assign captureNow = errReport && !logLocked;

  // ****************************************************************
  // Lock: first error wins, a new error beats a rearm
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      logLocked <= 1'b0;
    end else if (errReport) begin
      logLocked <= 1'b1;
    end else if (errLogRearm) begin
      logLocked <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      firstErrorIndex <= pcie_ext_cap_pkg::RST_FIRST_ERROR;
    end else if (captureNow) begin
      firstErrorIndex <= errIndex;
    end
  end

  for (genvar w = 0; w < pcie_ext_cap_pkg::HEADER_LOG_WORDS; w++) begin : gLog
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        headerLogWord[w] <= pcie_ext_cap_pkg::RST_HEADER_LOG;
      end else if (captureNow) begin
        headerLogWord[w] <= errHeader[w];
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence firstErrorSeen;
    errReport && !logLocked;
  endsequence

  first_index_capture_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      firstErrorSeen |=> firstErrorIndex == $past(errIndex))
    else $error("first error index not captured");

  log_hold_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      logLocked && !errLogRearm |=> logLocked && $stable(headerLogWord[0])
        && $stable(headerLogWord[3]) && $stable(firstErrorIndex))
    else $error("header log changed while locked");

endmodule : error_header_log

// ==== src/pcie_ext_capability_regs.sv ====
`timescale 1ns/100ps

// Function
// - Read-only bits 4:0 of error control hold index of first reported error.
// - Bit 5 of error control reports CRC generation capability, default one.
// - CRC generation only while sticky enable bit 6 is set; resets to zero.
// - Bit 7 of error control reports CRC check capability, default one.
// - CRC checking only while sticky enable bit 8 is set; resets to zero.
// - Four header words of first uncorrectable error logged, lowest address first.
// - Serial number header returns identifier 0x3 and version 0x1 in 19:16.
// - Low 32 bits of unique identifier read at offset 0x184.
// - High 32 bits of identifier, sticky, at offset 0x188, reset zero.
// - VC header at 0x200 returns identifier 0x2 and version 0x1.
// - VC next-capability field 31:20 defaults to zero, ending the list.
module pcie_ext_capability_regs (
  // Clock and resets
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hotReset,
  // Configuration requests
  input  wire logic        cfgWrite,
  input  wire logic        cfgRead,
  input  wire logic [11:0] cfgAddr,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWdata,
  input  wire logic        cfgUnlock,
  output logic             cfgAck,
  output logic [31:0]      cfgRdata,
  // Error capture
  input  wire logic        errReport,
  input  wire logic [4:0]  errIndex,
  input  wire logic [31:0] errHeader [pcie_ext_cap_pkg::HEADER_LOG_WORDS],
  input  wire logic        errLogRearm,
  // Transaction layer controls
  output logic             crcGenCapable,
  output logic             crcGenEnable,
  output logic             crcCheckCapable,
  output logic             crcCheckEnable
);

  logic        logLocked;
  logic [4:0]  firstErrorIndex;
  logic [31:0] headerLogWord [pcie_ext_cap_pkg::HEADER_LOG_WORDS];
  logic [11:0] serialNext_reg;
  logic [11:0] vcNext_reg;
  logic [31:0] serialLow_reg;
  logic [31:0] serialHigh_reg;
  logic [31:0] readData_next;
  logic        ctrlWrite;
  logic        lockedWrite;
  logic [31:0] ctrlMerged;
  logic [31:0] serialHdrMerged;
  logic [31:0] vcHdrMerged;
  logic [31:0] ctrlWord;

  // ****************************************************************
  // Byte-lane merge
  // ****************************************************************
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0]  byteEn);
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++) begin
      if (byteEn[b]) begin
        res[b*8 +: 8] = newVal[b*8 +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  assign ctrlWord = {23'h0, crcCheckEnable, crcCheckCapable, crcGenEnable,
                     crcGenCapable, firstErrorIndex};
  assign ctrlWrite       = cfgWrite && (cfgAddr == pcie_ext_cap_pkg::OFS_ERROR_CONTROL);
  assign lockedWrite     = cfgWrite && cfgUnlock;
  assign ctrlMerged      = mergeBytes(ctrlWord, cfgWdata, cfgByteEn);
  assign serialHdrMerged = mergeBytes({serialNext_reg, 20'h0}, cfgWdata, cfgByteEn);
  assign vcHdrMerged     = mergeBytes({vcNext_reg, 20'h0}, cfgWdata, cfgByteEn);

  // ****************************************************************
  // First error pointer and header log
  // ****************************************************************
  error_header_log uLog (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .errReport       (errReport),
    .errIndex        (errIndex),
    .errHeader       (errHeader),
    .errLogRearm     (errLogRearm),
    .logLocked       (logLocked),
    .firstErrorIndex (firstErrorIndex),
    .headerLogWord   (headerLogWord)
  );

  // ****************************************************************
  // Capability bits, lockable, set to one by any reset
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      crcGenCapable   <= pcie_ext_cap_pkg::RST_CRC_GEN_CAPABLE;
      crcCheckCapable <= pcie_ext_cap_pkg::RST_CRC_CHK_CAPABLE;
    end else if (hotReset) begin
      crcGenCapable   <= pcie_ext_cap_pkg::RST_CRC_GEN_CAPABLE;
      crcCheckCapable <= pcie_ext_cap_pkg::RST_CRC_CHK_CAPABLE;
    end else if (ctrlWrite && cfgUnlock) begin
      crcGenCapable   <= ctrlMerged[pcie_ext_cap_pkg::FLD_CRC_GEN_CAPABLE];
      crcCheckCapable <= ctrlMerged[pcie_ext_cap_pkg::FLD_CRC_CHECK_CAPABLE];
    end
  end

  // ****************************************************************
  // Sticky enables, power-on reset only
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      crcGenEnable   <= pcie_ext_cap_pkg::RST_CRC_GEN_ENABLE;
      crcCheckEnable <= pcie_ext_cap_pkg::RST_CRC_CHK_ENABLE;
    end else if (ctrlWrite) begin
      crcGenEnable   <= ctrlMerged[pcie_ext_cap_pkg::FLD_CRC_GEN_ENABLE];
      crcCheckEnable <= ctrlMerged[pcie_ext_cap_pkg::FLD_CRC_CHECK_ENABLE];
    end
  end

  // ****************************************************************
  // Next-capability fields, lockable
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serialNext_reg <= pcie_ext_cap_pkg::RST_NEXT_CAP;
      vcNext_reg     <= pcie_ext_cap_pkg::RST_NEXT_CAP;
    end else if (hotReset) begin
      serialNext_reg <= pcie_ext_cap_pkg::RST_NEXT_CAP;
      vcNext_reg     <= pcie_ext_cap_pkg::RST_NEXT_CAP;
    end else if (lockedWrite) begin
      if (cfgAddr == pcie_ext_cap_pkg::OFS_SERIAL_CAP_HDR) begin
        serialNext_reg <= serialHdrMerged[31:20];
      end
      if (cfgAddr == pcie_ext_cap_pkg::OFS_VC_CAP_HDR) begin
        vcNext_reg <= vcHdrMerged[31:20];
      end
    end
  end

  // ****************************************************************
  // Serial number words
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serialLow_reg <= pcie_ext_cap_pkg::RST_SERIAL_LOW;
    end else if (hotReset) begin
      serialLow_reg <= pcie_ext_cap_pkg::RST_SERIAL_LOW;
    end else if (lockedWrite && cfgAddr == pcie_ext_cap_pkg::OFS_SERIAL_LOW) begin
      serialLow_reg <= mergeBytes(serialLow_reg, cfgWdata, cfgByteEn);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serialHigh_reg <= pcie_ext_cap_pkg::RST_SERIAL_HIGH;
    end else if (lockedWrite && cfgAddr == pcie_ext_cap_pkg::OFS_SERIAL_HIGH) begin
      serialHigh_reg <= mergeBytes(serialHigh_reg, cfgWdata, cfgByteEn);
    end
  end

  // ****************************************************************
  // Read decode
  // ****************************************************************
  always_comb begin
    unique case (cfgAddr)
      pcie_ext_cap_pkg::OFS_ERROR_CONTROL:  readData_next = ctrlWord;
      pcie_ext_cap_pkg::OFS_HEADER_LOG_1:   readData_next = headerLogWord[0];
      pcie_ext_cap_pkg::OFS_HEADER_LOG_2:   readData_next = headerLogWord[1];
      pcie_ext_cap_pkg::OFS_HEADER_LOG_3:   readData_next = headerLogWord[2];
      pcie_ext_cap_pkg::OFS_HEADER_LOG_4:   readData_next = headerLogWord[3];
      pcie_ext_cap_pkg::OFS_SERIAL_CAP_HDR: readData_next = {serialNext_reg,
        pcie_ext_cap_pkg::SERIAL_CAP_VER, pcie_ext_cap_pkg::SERIAL_CAP_ID};
      pcie_ext_cap_pkg::OFS_SERIAL_LOW:     readData_next = serialLow_reg;
      pcie_ext_cap_pkg::OFS_SERIAL_HIGH:    readData_next = serialHigh_reg;
      pcie_ext_cap_pkg::OFS_VC_CAP_HDR:     readData_next = {vcNext_reg,
        pcie_ext_cap_pkg::VC_CAP_VER, pcie_ext_cap_pkg::VC_CAP_ID};
      default:                              readData_next = pcie_ext_cap_pkg::READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfgAck   <= 1'b0;
      cfgRdata <= pcie_ext_cap_pkg::READ_UNMAPPED;
    end else begin
      cfgAck   <= cfgWrite || cfgRead;
      cfgRdata <= cfgRead ? readData_next : pcie_ext_cap_pkg::READ_UNMAPPED;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence ctrlWriteLow;
    cfgWrite && !hotReset && cfgAddr == pcie_ext_cap_pkg::OFS_ERROR_CONTROL && cfgByteEn[0];
  endsequence

  sequence ctrlWriteHigh;
    cfgWrite && cfgAddr == pcie_ext_cap_pkg::OFS_ERROR_CONTROL && cfgByteEn[1];
  endsequence

  gen_capable_reset_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      hotReset |=> crcGenCapable)
    else $error("generation capable not restored");

  gen_enable_write_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      ctrlWriteLow |=> crcGenEnable == $past(cfgWdata[6]))
    else $error("generation enable not written");

  check_capable_reset_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      hotReset |=> crcCheckCapable)
    else $error("check capable not restored");

  check_enable_write_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      ctrlWriteHigh |=> crcCheckEnable == $past(cfgWdata[8]))
    else $error("check enable not written");

  serial_header_read_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      cfgRead && cfgAddr == pcie_ext_cap_pkg::OFS_SERIAL_CAP_HDR
        |=> cfgAck && cfgRdata[19:0] == 20'h10003)
    else $error("serial header identity wrong");

  serial_low_read_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      cfgRead && cfgAddr == pcie_ext_cap_pkg::OFS_SERIAL_LOW
        |=> cfgRdata == $past(serialLow_reg))
    else $error("serial low word wrong");

  serial_high_sticky_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      hotReset && !cfgWrite |=> $stable(serialHigh_reg))
    else $error("serial high lost on hot reset");

  vc_header_read_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      cfgRead && cfgAddr == pcie_ext_cap_pkg::OFS_VC_CAP_HDR
        |=> cfgRdata[19:0] == 20'h10002)
    else $error("vc header identity wrong");

  vc_next_default_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      hotReset |=> vcNext_reg == 12'h000)
    else $error("vc next pointer not cleared");

  enables_sticky_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      hotReset && !cfgWrite |=> $stable(crcGenEnable) && $stable(crcCheckEnable))
    else $error("sticky enable lost on hot reset");

endmodule : pcie_ext_capability_regs

// ==== bench/cfg_requester.sv ====
`timescale 1ns/100ps

// ****
// Config requester
// ****
module cfg_requester (
  // Clock
  input  wire logic        sys_clk,
  // Configuration bus
  output logic             cfgWrite,
  output logic             cfgRead,
  output logic [11:0]      cfgAddr,
  output logic [3:0]       cfgByteEn,
  output logic [31:0]      cfgWdata,
  input  wire logic        cfgAck,
  input  wire logic [31:0] cfgRdata
);
  initial begin
    cfgWrite = 1'h0;
    cfgRead = 1'h0;
    cfgAddr = 12'h000;
    cfgByteEn = 4'h0;
    cfgWdata = 32'h0000_0000;
  end

  // One-cycle request; answer taken in the following cycle
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [3:0] be,
                      input logic [31:0] d, output logic ack, output logic [31:0] q);
    @(negedge sys_clk);
    cfgWrite = wr;
    cfgRead = !wr;
    cfgAddr = a;
    cfgByteEn = be;
    cfgWdata = d;
    @(negedge sys_clk);
    cfgWrite = 1'h0;
    cfgRead = 1'h0;
    ack = cfgAck;
    q = cfgRdata;
    // Released lines must not keep the last value
    cfgAddr = ~a;
    cfgWdata = ~d;
    cfgByteEn = ~be;
  endtask : xfer
endmodule : cfg_requester

// ==== bench/test_pcie_ext_capability_regs.sv ====
`timescale 1ns/100ps

`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", what, exp, got); end end

module test_pcie_ext_capability_regs;
  // ****
  // Signals
  // ****
  logic        sys_clk, rst, hotReset, cfgUnlock, errReport, errLogRearm;
  logic        cfgWrite, cfgRead, cfgAck;
  logic        crcGenCapable, crcGenEnable, crcCheckCapable, crcCheckEnable;
  logic [11:0] cfgAddr;
  logic [3:0]  cfgByteEn;
  logic [31:0] cfgWdata, cfgRdata;
  logic [4:0]  errIndex;
  logic [31:0] errHeader [pcie_ext_cap_pkg::HEADER_LOG_WORDS];
  int          error_cnt = 0;
  int          cmp_count = 0;

  pcie_ext_capability_regs pcie_ext_capability_regs_i (.sys_clk(sys_clk), .rst(rst),
    .hotReset(hotReset), .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn), .cfgWdata(cfgWdata), .cfgUnlock(cfgUnlock), .cfgAck(cfgAck),
    .cfgRdata(cfgRdata), .errReport(errReport), .errIndex(errIndex),
    .errHeader(errHeader), .errLogRearm(errLogRearm), .crcGenCapable(crcGenCapable),
    .crcGenEnable(crcGenEnable), .crcCheckCapable(crcCheckCapable),
    .crcCheckEnable(crcCheckEnable));

  cfg_requester cfg_requester_i (.sys_clk(sys_clk), .cfgWrite(cfgWrite),
    .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWdata(cfgWdata),
    .cfgAck(cfgAck), .cfgRdata(cfgRdata));

  always #5 sys_clk = ~sys_clk;

  // ****
  // Helpers
  // ****
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    logic        ack;
    logic [31:0] q;
    cfg_requester_i.xfer(1'h1, a, be, d, ack, q);
    `CHK("write ack", 1'h1, ack)
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic        ack;
    logic [31:0] q;
    cfg_requester_i.xfer(1'h0, a, 4'hF, 32'h0000_0000, ack, q);
    `CHK("read ack", 1'h1, ack)
    `CHK($sformatf("reg %h", a), e, q)
  endtask : rd

  task automatic logs(input logic [31:0] base, input logic inc = 1'h1);
    for (int i = 0; i < 4; i++) begin
      rd(12'h11C + 12'(4 * i), base + (inc ? 32'(i) : 32'h0000_0000));
    end
  endtask : logs

  task automatic err(input logic [4:0] idx, input logic [31:0] base, input logic rearm);
    @(negedge sys_clk);
    errLogRearm = rearm;
    @(negedge sys_clk);
    errLogRearm = 1'h0;
    errReport = 1'h1;
    errIndex = idx;
    for (int i = 0; i < 4; i++) begin
      errHeader[i] = base + 32'(i);
    end
    @(negedge sys_clk);
    errReport = 1'h0;
  endtask : err

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // ****
  // Scenarios
  // ****
  task automatic test_reset_values;
    rd(12'h118, 32'h0000_00A0);
    logs(32'h0000_0000, 1'h0);
    rd(12'h180, 32'h0001_0003);
    rd(12'h184, 32'h0000_0000);
    rd(12'h188, 32'h0000_0000);
    rd(12'h200, 32'h0001_0002);
    rd(12'h204, 32'h0000_0000);
    `CHK("gen capable", 1'h1, crcGenCapable)
    `CHK("chk capable", 1'h1, crcCheckCapable)
    $display("done reset_values");
  endtask : test_reset_values

  task automatic test_control;
    wr(12'h118, 32'hFFFF_FFFF);
    rd(12'h118, 32'h0000_01E0);
    `CHK("gen enable", 1'h1, crcGenEnable)
    `CHK("chk enable", 1'h1, crcCheckEnable)
    wr(12'h118, 32'h0000_0000, 4'h1);
    rd(12'h118, 32'h0000_01A0);
    `CHK("gen enable off", 1'h0, crcGenEnable)
    cfgUnlock = 1'h1;
    wr(12'h118, 32'h0000_0100);
    rd(12'h118, 32'h0000_0100);
    `CHK("gen capable off", 1'h0, crcGenCapable)
    `CHK("chk capable off", 1'h0, crcCheckCapable)
    $display("done control");
  endtask : test_control

  task automatic test_capture;
    err(5'h07, 32'hA000_0000, 1'h0);
    rd(12'h118, 32'h0000_0107);
    logs(32'hA000_0000);
    err(5'h03, 32'hB000_0000, 1'h0);
    rd(12'h118, 32'h0000_0107);
    logs(32'hA000_0000);
    err(5'h1F, 32'hC000_0000, 1'h1);
    rd(12'h118, 32'h0000_011F);
    logs(32'hC000_0000);
    $display("done capture");
  endtask : test_capture

  task automatic test_serial;
    wr(12'h184, 32'h89AB_CDEF);
    wr(12'h188, 32'h0123_4567);
    wr(12'h184, 32'h0000_0055, 4'h1);
    rd(12'h184, 32'h89AB_CD55);
    rd(12'h188, 32'h0123_4567);
    wr(12'h180, 32'hFFFF_FFFF);
    rd(12'h180, 32'hFFF1_0003);
    wr(12'h200, 32'hFFFF_FFFF);
    rd(12'h200, 32'hFFF1_0002);
    cfgUnlock = 1'h0;
    wr(12'h188, 32'h0000_0000);
    rd(12'h188, 32'h0123_4567);
    $display("done serial");
  endtask : test_serial

  task automatic test_resets;
    @(negedge sys_clk);
    hotReset = 1'h1;
    @(negedge sys_clk);
    hotReset = 1'h0;
    rd(12'h118, 32'h0000_01BF);
    logs(32'hC000_0000);
    rd(12'h184, 32'h0000_0000);
    rd(12'h188, 32'h0123_4567);
    rd(12'h180, 32'h0001_0003);
    rd(12'h200, 32'h0001_0002);
    @(negedge sys_clk);
    rst = 1'h1;
    @(negedge sys_clk);
    rst = 1'h0;
    rd(12'h118, 32'h0000_00A0);
    logs(32'h0000_0000, 1'h0);
    rd(12'h188, 32'h0000_0000);
    $display("done resets");
  endtask : test_resets

  // ****
  // Main sequence
  // ****
  initial begin
    sys_clk = 1'h0;
    rst = 1'h1;
    hotReset = 1'h0;
    cfgUnlock = 1'h0;
    errReport = 1'h0;
    errLogRearm = 1'h0;
    errIndex = 5'h00;
    for (int i = 0; i < 4; i++) begin
      errHeader[i] = 32'h0000_0000;
    end
    repeat (5) @(negedge sys_clk);
    rst = 1'h0;
    test_reset_values();
    test_control();
    test_capture();
    test_serial();
    test_resets();
    tally_and_finish();
  end

  // Watchdog, far beyond the roughly 130 cycles needed
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : test_pcie_ext_capability_regs
